/* File: verilog/fan_pwm_low_freq.sv */
/*
 Low-frequency drive for fan channels one and two, with the combined
 minimum-duty select and rate register, a control register, two duty
 registers and a status register, all on an Avalon-MM slave.
 Assumes the bus master is on clk and the automatic loop state is written
 into the control register by software or firmware.
*/
`timescale 1ns/1ns

// Notes on behaviour
// RQ1: Channel one below threshold: zero or minimum.
// RQ2: Channel two below threshold: zero or minimum.
// RQ3: Bits 4:2 pick channel one rate.
// RQ4: Bits 7:5 pick channel two rate.
// RQ5: Register powers up reading 0x90.
// RQ6: Lock blocks writes; software reset restores default.
// RQ7: New rate applies at period boundary.
module fan_pwm_low_freq #(
  parameter longint CLK_HZ = fan_pwm_pkg::CLK_FREQ_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic fanDriveChannelOne,
  output logic fanDriveChannelTwo
);

  logic [7:0] freqCfg_reg, freqCfg_next;
  logic lock_reg, lock_next;
  logic [1:0] autoMode_reg, autoMode_next;
  logic [1:0] belowStart_reg, belowStart_next;
  logic [15:0] duty_reg [2];
  logic [15:0] duty_next [2];
  logic [31:0] readdata_reg, readdata_next;
  logic waitrequest_reg, waitrequest_next;
  logic [2:0] activeRate [2];
  logic [7:0] activeDuty [2];
  logic [1:0] pwmLevel;
  logic accept;

  // Step length in clocks for one of the 256 duty steps at a given rate.
  function automatic logic [31:0] stepCycles(input logic [2:0] code);
    longint steps;
    steps = (CLK_HZ * 10) / (fan_pwm_pkg::rateDeciHz(code) * fan_pwm_pkg::DUTY_STEPS);
    stepCycles = (steps < 1) ? 32'h0000_0001 : 32'(steps);
  endfunction

  // A request is served on the second edge, once waitrequest has dropped.
  assign accept = (read || write) && !waitrequest_reg;

  // Register file and bus handshake: next values.
  always_comb begin
    freqCfg_next = freqCfg_reg;
    lock_next = lock_reg;
    autoMode_next = autoMode_reg;
    belowStart_next = belowStart_reg;
    duty_next = duty_reg;
    readdata_next = readdata_reg;
    waitrequest_next = 1'b1;
    if ((read || write) && waitrequest_reg) begin
      waitrequest_next = 1'b0;
      readdata_next = 32'h0000_0000;
      if (read) begin
        case (address)
          fan_pwm_pkg::FREQ_CFG_ADDR: readdata_next[7:0] = freqCfg_reg;
          fan_pwm_pkg::CTRL_ADDR: begin
            readdata_next[fan_pwm_pkg::CTRL_LOCK_BIT] = lock_reg;
            readdata_next[fan_pwm_pkg::CTRL_AUTO_LSB +: 2] = autoMode_reg;
            readdata_next[fan_pwm_pkg::CTRL_BELOW_LSB +: 2] = belowStart_reg;
          end
          fan_pwm_pkg::DUTY1_ADDR: readdata_next[15:0] = duty_reg[0];
          fan_pwm_pkg::DUTY2_ADDR: readdata_next[15:0] = duty_reg[1];
          fan_pwm_pkg::STATUS_ADDR: begin
            readdata_next[fan_pwm_pkg::STAT_RATE_LSB +: 3] = activeRate[0];
            readdata_next[fan_pwm_pkg::STAT_RATE_LSB + 3 +: 3] = activeRate[1];
            readdata_next[fan_pwm_pkg::STAT_DUTY_LSB +: 8] = activeDuty[0];
            readdata_next[fan_pwm_pkg::STAT_DUTY_LSB + 8 +: 8] = activeDuty[1];
          end
          default: readdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (accept && write) begin
      case (address)
        // RQ6: lock gates writes
        fan_pwm_pkg::FREQ_CFG_ADDR: begin
          if (byteenable[0] && !lock_reg) begin
            freqCfg_next = writedata[7:0];
          end
        end
        fan_pwm_pkg::CTRL_ADDR: begin
          if (byteenable[0]) begin
            // RQ6: sticky lock bit
            lock_next = lock_reg | writedata[fan_pwm_pkg::CTRL_LOCK_BIT];
            autoMode_next = writedata[fan_pwm_pkg::CTRL_AUTO_LSB +: 2];
            belowStart_next = writedata[fan_pwm_pkg::CTRL_BELOW_LSB +: 2];
            // RQ6: software reset default
            if (writedata[fan_pwm_pkg::CTRL_SWRST_BIT]) begin
              freqCfg_next = fan_pwm_pkg::FREQ_CFG_RESET;
            end
          end
        end
        fan_pwm_pkg::DUTY1_ADDR, fan_pwm_pkg::DUTY2_ADDR: begin
          for (int i = 0; i < 2; i++) begin
            if (address == (i == 0 ? fan_pwm_pkg::DUTY1_ADDR : fan_pwm_pkg::DUTY2_ADDR)) begin
              if (byteenable[0]) begin
                duty_next[i][7:0] = writedata[7:0];
              end
              if (byteenable[1]) begin
                duty_next[i][15:8] = writedata[15:8];
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register file and bus handshake: state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // RQ5: power-on value
      freqCfg_reg <= fan_pwm_pkg::FREQ_CFG_RESET;
      lock_reg <= 1'b0;
      autoMode_reg <= 2'h0;
      belowStart_reg <= 2'h0;
      duty_reg[0] <= 16'h0000;
      duty_reg[1] <= 16'h0000;
      readdata_reg <= 32'h0000_0000;
      waitrequest_reg <= 1'b1;
    end else begin
      freqCfg_reg <= freqCfg_next;
      lock_reg <= lock_next;
      autoMode_reg <= autoMode_next;
      belowStart_reg <= belowStart_next;
      duty_reg <= duty_next;
      readdata_reg <= readdata_next;
      waitrequest_reg <= waitrequest_next;
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;

  // One drive engine per channel; both share the same structure.
  for (genvar ch = 0; ch < 2; ch++) begin : chan
    logic [2:0] rate_reg, rate_next;
    logic [7:0] dutyHeld_reg, dutyHeld_next;
    logic [31:0] stepCnt_reg, stepCnt_next;
    logic [7:0] phase_reg, phase_next;
    logic pwm_reg, pwm_next;
    logic [2:0] wantedRate;
    logic [7:0] wantedDuty;

    // RQ3: channel one rate field
    // RQ4: channel two rate field
    assign wantedRate = freqCfg_reg[(ch == 0 ? fan_pwm_pkg::RATE_LSB_CH1 : fan_pwm_pkg::RATE_LSB_CH2) +:
                                    fan_pwm_pkg::RATE_WIDTH];

    // The below-threshold floor only applies while the automatic loop owns the channel.
    always_comb begin
      wantedDuty = duty_reg[ch][fan_pwm_pkg::DUTY_LSB +: 8];
      // RQ1: channel one floor
      // RQ2: channel two floor
      if (autoMode_reg[ch] && belowStart_reg[ch]) begin
        wantedDuty = freqCfg_reg[fan_pwm_pkg::MIN_SEL_BIT + ch] ? duty_reg[ch][fan_pwm_pkg::MIN_DUTY_LSB +: 8]
                                                                 : fan_pwm_pkg::DUTY_OFF;
      end
    end

    // Period counter; rate and duty are sampled only when a period wraps.
    always_comb begin
      rate_next = rate_reg;
      dutyHeld_next = dutyHeld_reg;
      stepCnt_next = stepCnt_reg + 32'h0000_0001;
      phase_next = phase_reg;
      if (stepCnt_reg >= stepCycles(rate_reg) - 32'h0000_0001) begin
        stepCnt_next = 32'h0000_0000;
        phase_next = phase_reg + 8'h01;
        // RQ7: boundary update
        if (phase_reg == fan_pwm_pkg::DUTY_FULL) begin
          rate_next = wantedRate;
          dutyHeld_next = wantedDuty;
        end
      end
      pwm_next = (dutyHeld_next == fan_pwm_pkg::DUTY_FULL) || (phase_next < dutyHeld_next);
    end

    // Engine state; starts at the default rate with the output low.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rate_reg <= fan_pwm_pkg::FREQ_CFG_RESET[fan_pwm_pkg::RATE_LSB_CH1 +: fan_pwm_pkg::RATE_WIDTH];
        dutyHeld_reg <= 8'h00;
        stepCnt_reg <= 32'h0000_0000;
        phase_reg <= 8'h00;
        pwm_reg <= 1'b0;
      end else begin
        rate_reg <= rate_next;
        dutyHeld_reg <= dutyHeld_next;
        stepCnt_reg <= stepCnt_next;
        phase_reg <= phase_next;
        pwm_reg <= pwm_next;
      end
    end

    assign activeRate[ch] = rate_reg;
    assign activeDuty[ch] = dutyHeld_reg;
    assign pwmLevel[ch] = pwm_reg;
  end

  assign fanDriveChannelOne = pwmLevel[0];
  assign fanDriveChannelTwo = pwmLevel[1];

endmodule

/* File: verilog/fan_pwm_pkg.sv */
/*
 Shared constants for the low-frequency fan drive block: register byte
 addresses, field positions, reset values and the rate table.
 Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package fan_pwm_pkg;

  // Word index of the frequency register; the bus address is four times it.
  localparam logic [7:0] FREQ_CFG_INDEX = 8'h25;
  localparam logic [7:0] FREQ_CFG_ADDR = 8'(FREQ_CFG_INDEX * 4);
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] DUTY1_ADDR = 8'h04;
  localparam logic [7:0] DUTY2_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;

  // Frequency register layout and power-on value.
  localparam logic [7:0] FREQ_CFG_RESET = 8'h90;
  localparam int MIN_SEL_BIT = 0;
  localparam int RATE_LSB_CH1 = 2;
  localparam int RATE_LSB_CH2 = 5;
  localparam int RATE_WIDTH = 3;

  // Control register layout.
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_SWRST_BIT = 1;
  localparam int CTRL_AUTO_LSB = 2;
  localparam int CTRL_BELOW_LSB = 4;

  // Duty register layout: requested duty low byte, minimum duty next byte.
  localparam int DUTY_LSB = 0;
  localparam int MIN_DUTY_LSB = 8;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF = 8'h00;

  // Status register layout.
  localparam int STAT_RATE_LSB = 0;
  localparam int STAT_DUTY_LSB = 8;

  // Clock rate and the number of duty steps in one period.
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam longint DUTY_STEPS = 256;

  // Output rates in tenths of a hertz, indexed by the rate code.
  function automatic longint rateDeciHz(input logic [2:0] code);
    case (code)
      3'h0: rateDeciHz = 110;
      3'h1: rateDeciHz = 147;
      3'h2: rateDeciHz = 221;
      3'h3: rateDeciHz = 294;
      3'h4: rateDeciHz = 353;
      3'h5: rateDeciHz = 441;
      3'h6: rateDeciHz = 588;
      default: rateDeciHz = 882;
    endcase
  endfunction

endpackage

/* File: tb/fan_pwm_monitor.sv */
/* Port checker for the fan drive block.
 Assumes it is bound onto the block and shares its clock and reset. */
`timescale 1ns/1ns
module fan_pwm_monitor #(
  parameter longint CLK_HZ = 100_000_000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic fanDriveChannelOne,
  input wire logic fanDriveChannelTwo
);
  // Two periods at the slowest code plus slack, since duty only changes at a wrap.
  localparam longint LIMIT = 512 * (CLK_HZ * 10 / (110 * 256)) + 4;
  logic [7:0] shadow_reg;
  logic [3:0] loop_reg;
  logic lock_reg;
  longint quietOne_reg;
  longint quietTwo_reg;
  logic taken;
  assign taken = write && !waitrequest && byteenable[0];
  // Shadow state follows accepted writes; the lock stays until hardware reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= 8'h90;
      loop_reg <= 4'h0;
      lock_reg <= 1'b0;
    end else if (taken && address == fan_pwm_pkg::FREQ_CFG_ADDR && !lock_reg) begin
      shadow_reg <= writedata[7:0];
    end else if (taken && address == fan_pwm_pkg::CTRL_ADDR) begin
      loop_reg <= writedata[5:2];
      lock_reg <= lock_reg | writedata[0];
      if (writedata[1]) begin
        shadow_reg <= 8'h90;
      end
    end
  end
  // Count how long each channel has been told to sit fully off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quietOne_reg <= 0;
      quietTwo_reg <= 0;
    end else begin
      quietOne_reg <= (loop_reg[0] && loop_reg[2] && !shadow_reg[0]) ? quietOne_reg + 1 : 0;
      quietTwo_reg <= (loop_reg[1] && loop_reg[3] && !shadow_reg[1]) ? quietTwo_reg + 1 : 0;
    end
  end
  freq_read_a: assert property (@(posedge clk) disable iff (rst)
    read && !waitrequest && address == fan_pwm_pkg::FREQ_CFG_ADDR |-> readdata[7:0] == shadow_reg)
    else $error("frequency register read back wrong");
  swrst_default_a: assert property (@(posedge clk) disable iff (rst)
    (taken && address == fan_pwm_pkg::CTRL_ADDR && writedata[1]) ##[2:3] (read && !waitrequest
    && address == fan_pwm_pkg::FREQ_CFG_ADDR) |-> readdata[7:0] == 8'h90) else $error("software reset missed");
  ack_prompt_a: assert property (@(posedge clk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
  ack_single_a: assert property (@(posedge clk) disable iff (rst)
    !waitrequest |=> waitrequest) else $error("bus answer too long");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (rst)
    read && !waitrequest && address == 8'hF0 |-> readdata == 32'h00000000) else $error("unmapped read not zero");
  quiet_one_a: assert property (@(posedge clk) disable iff (rst)
    quietOne_reg > LIMIT |-> !fanDriveChannelOne) else $error("channel one not off");
  quiet_two_a: assert property (@(posedge clk) disable iff (rst)
    quietTwo_reg > LIMIT |-> !fanDriveChannelTwo) else $error("channel two not off");
  cover property (@(posedge clk) quietOne_reg > LIMIT);
  cover property (@(posedge clk) quietTwo_reg > LIMIT);
  cover property (@(posedge clk) lock_reg && taken && address == fan_pwm_pkg::FREQ_CFG_ADDR);
endmodule

bind fan_pwm_low_freq fan_pwm_monitor #(.CLK_HZ(CLK_HZ)) monitor (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .fanDriveChannelOne(fanDriveChannelOne), .fanDriveChannelTwo(fanDriveChannelTwo));

/* File: tb/fan_load_model.sv */
/* Behavioural fan load that times each drive pulse.
 Assumes the drive changes only just after clk edges. */
`timescale 1ns/1ns
module fan_load_model (
  input wire logic clk,
  input wire logic drive,
  output int period,
  output int highTime,
  output int pulses
);
  logic prev_reg = 1'b0;
  int cnt_reg = 0;
  int hi_reg = 0;
  // A fan only feels rising edges and high time, so period runs rise to rise.
  always @(posedge clk) begin
    prev_reg <= drive;
    cnt_reg <= cnt_reg + 1;
    hi_reg <= hi_reg + int'(drive);
    if (drive && !prev_reg) begin
      period <= cnt_reg;
      highTime <= hi_reg;
      pulses <= pulses + 1;
      cnt_reg <= 1;
      hi_reg <= 1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
/* Self-checking bench for the fan drive block with two fan loads.
 Assumes one low waitrequest cycle answers each bus request. */
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic fanDriveChannelOne;
  logic fanDriveChannelTwo;
  logic [31:0] rd;
  int period1, high1, pulses1, period2, high2, pulses2;
  int mismatches = 0;
  int num_checks = 0;
  localparam int RATE[8] = '{110, 147, 221, 294, 353, 441, 588, 882};
  localparam logic [7:0] FREQ = fan_pwm_pkg::FREQ_CFG_ADDR;
  // A small clock figure keeps periods short: one step is 1000 / rate clocks.
  fan_pwm_low_freq #(.CLK_HZ(25600)) dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fanDriveChannelOne(fanDriveChannelOne), .fanDriveChannelTwo(fanDriveChannelTwo));
  fan_load_model fanOne (.clk(clk), .drive(fanDriveChannelOne), .period(period1), .highTime(high1), .pulses(pulses1));
  fan_load_model fanTwo (.clk(clk), .drive(fanDriveChannelTwo), .period(period2), .highTime(high2), .pulses(pulses2));
  // The 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus requests are held until waitrequest is sampled low.
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // Waits for further rising edges on each fan; the watchdog bounds it.
  // Two edges pass first, so a wrap that loaded the old setting just before is not counted.
  task automatic settle(input int n1, input int n2);
    int t1;
    int t2;
    repeat (2) @(posedge clk);
    t1 = pulses1 + n1;
    t2 = pulses2 + n2;
    wait (pulses1 >= t1 && pulses2 >= t2);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    int s1;
    int s2;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    access(1'b0, FREQ, 32'h0);
    check(32'(rd[7:0]), 32'h00000090);
    access(1'b1, 8'hF0, 32'hFFFFFFFF);
    access(1'b0, 8'hF0, 32'h0);
    check(rd, 32'h00000000);
    access(1'b1, fan_pwm_pkg::DUTY1_ADDR, 32'h00000080);
    access(1'b1, fan_pwm_pkg::DUTY2_ADDR, 32'h00000040);
    // Every rate code on channel one, the mirrored code on channel two.
    for (int c = 0; c < 8; c++) begin
      access(1'b1, FREQ, 32'((7 - c) * 32 + c * 4));
      // The first rise after the new code still closes a whole period at the old rate.
      repeat (2) @(posedge clk);
      s1 = pulses1;
      s2 = pulses2;
      fork
        begin
          wait (pulses1 > s1);
          if (c > 0) check(period1, 256 * (1000 / RATE[c - 1]));
        end
        begin
          wait (pulses2 > s2);
          if (c > 0) check(period2, 256 * (1000 / RATE[8 - c]));
        end
      join
      settle(1, 1);
      s1 = 1000 / RATE[c];
      s2 = 1000 / RATE[7 - c];
      check(period1, 256 * s1);
      check(high1, 128 * s1);
      check(period2, 256 * s2);
      check(high2, 64 * s2);
    end
    // Both loops below threshold; only the selected channel keeps its minimum.
    access(1'b1, fan_pwm_pkg::DUTY1_ADDR, 32'h00002080);
    access(1'b1, fan_pwm_pkg::DUTY2_ADDR, 32'h00001040);
    access(1'b1, fan_pwm_pkg::CTRL_ADDR, 32'h0000003C);
    access(1'b1, FREQ, 32'h000000FD);
    settle(2, 0);
    check(high1, 32'h00000020);
    repeat (5000) @(posedge clk);
    s2 = pulses2;
    settle(3, 0);
    check(pulses2, s2);
    access(1'b1, FREQ, 32'h000000FE);
    settle(0, 2);
    check(high2, 32'h00000010);
    repeat (5000) @(posedge clk);
    s1 = pulses1;
    settle(0, 3);
    check(pulses1, s1);
    // Locked writes are dropped; software reset still restores the default.
    access(1'b1, fan_pwm_pkg::CTRL_ADDR, 32'h00000001);
    access(1'b1, FREQ, 32'h00000055);
    access(1'b0, FREQ, 32'h0);
    check(32'(rd[7:0]), 32'h000000FE);
    access(1'b1, fan_pwm_pkg::CTRL_ADDR, 32'h00000002);
    access(1'b0, FREQ, 32'h0);
    check(32'(rd[7:0]), 32'h00000090);
    complete_run();
  end
  // The tests need at most about 34000 cycles, so 90000 marks a hang.
  initial begin
    #900000;
    mismatches++;
    complete_run();
  end
endmodule
